// ### design/output_control_params.svh
// constants for the output reset/enable control block
// assumes a 40 MHz core clock and word-aligned classic wishbone access
`ifndef OUTPUT_CONTROL_PARAMS_SVH
`define OUTPUT_CONTROL_PARAMS_SVH

// register indices; byte address is four times the index
`define RESET_AND_OUTPUT_ENABLE_INDEX      8'h32
`define CONFIG_INDEX      8'h33
`define OPSTAT_INDEX      8'h3E

// reset_and_output_enable fields
`define MR_BIT            0
`define SR_BIT            1
`define SOFTWARE_OUTPUT_ENABLE_BIT          3
`define RESET_AND_OUTPUT_ENABLE_RESET      16'h0000

// behaviour_configuration fields
`define ADT_BIT           1
`define SDF_BIT           2
`define CONFIG_RESET      16'h0002
`define CONFIG_WMASK      16'h0006

// fatal status layout
`define DIS_LATCH_BIT     12
`define FATAL_HI          10
`define FATAL_LO          8

// response status and error codes
`define ST_OK             2'h0
`define ST_XE             2'h1
`define ST_CP             2'h3
`define ERR_NONE          4'h0
`define ERR_CIP           4'h3
`define ERR_CII           4'h4
`define ERR_EXF           4'h8
`define PEND_ID           16'h0001

// operation status register fields
`define OS_ERR_LO         4
`define OS_PEND_BIT       8
`define OS_DIS_BIT        9
`define OS_OFF_BIT        10
`define OS_ALM_BIT        11
`define OS_SRQ_BIT        12
`define OS_DATA_LO        16

// timing: pending operation must finish within this time
`define CLK_HZ            40000000
`define PEND_LIMIT_MS     200
`define PEND_LIMIT_CYCLES (`PEND_LIMIT_MS * (`CLK_HZ / 1000))

`endif

// ### design/output_control_pkg.sv
// types shared by the output reset/enable control files
// assumes the constants header supplies all numbers
package output_control_pkg;
   typedef enum logic [0:0] {pend_idle, pend_wait} pend_state_t;
   typedef logic [15:0] reg16_t;
endpackage

// ### design/output_reset_enable_control.sv
// register bank for reset/enable and behaviour configuration, with
// the optical output-disable combiner; classic wishbone slave
// assumes all pins synchronous to core_clk, srst synchronous high
`timescale 1ns/100ps
`include "output_control_params.svh"
module output_reset_enable_control #(
   parameter int unsigned PEND_LIMIT = `PEND_LIMIT_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        hardware_output_disable_pin_n,
   input  wire logic        module_select_pin_n,
   input  wire logic [15:0] fatal_status_register,
   input  wire logic [15:0] fatal_trigger_mask,
   input  wire logic        tune_required,
   input  wire logic        tune_done,
   input  wire logic        tune_fail,
   input  wire logic        nvm_load,
   input  wire logic [15:0] nvm_config,
   output logic             tune_start,
   output logic             optical_output_enable,
   output logic             output_disable,
   output logic             alarm_signal,
   output logic             disable_latched,
   output logic             hard_reset_pulse,
   output logic             comm_interface_reset,
   output logic             ext_addr_reset,
   output logic             service_request_n
);
   localparam logic [7:0] ADDR_RESET_AND_OUTPUT_ENABLE = 8'(`RESET_AND_OUTPUT_ENABLE_INDEX * 4);
   localparam logic [7:0] ADDR_CONFIG = 8'(`CONFIG_INDEX * 4);
   localparam logic [7:0] ADDR_OPSTAT = 8'(`OPSTAT_INDEX * 4);

   output_control_pkg::reg16_t behaviour_configuration;
   logic                       software_output_enable;
   logic                       hard_arm;
   logic                       soft_reset_pulse;
   logic [1:0]                 resp_status;
   logic [3:0]                 resp_err;
   output_control_pkg::reg16_t resp_data;
   logic                       srq;
   logic                       take;
   logic                       wr;
   logic                       rd;
   logic                       sel_reset_and_output_enable;
   logic                       sel_config;
   logic                       sel_opstat;
   logic [31:0]                next_dat;
   logic [15:0]                wval;
   logic                       pin_low;
   logic                       deselected;
   logic                       cfg_read_fail;
   logic                       fatal_hit;
   logic [15:0]                fatal_view;

   pending_op_if pend ();

   // bounds the pending enable; hard reset aborts it
   pending_tracker #(
      .LIMIT (PEND_LIMIT)
   ) u_tracker (
      .core_clk  (core_clk),
      .srst      (srst),
      .abort     (hard_reset_pulse),
      .tune_done (tune_done),
      .tune_fail (tune_fail),
      .op        (pend)
   );

   // bus decode; effects land on the edge where ack is seen
   assign take       = wb_cyc_i && wb_stb_i && wb_ack_o;
   assign wr         = take && wb_we_i;
   assign rd         = take && !wb_we_i;
   assign sel_reset_and_output_enable = (wb_adr_i == ADDR_RESET_AND_OUTPUT_ENABLE);
   assign sel_config = (wb_adr_i == ADDR_CONFIG);
   assign sel_opstat = (wb_adr_i == ADDR_OPSTAT);
   assign pin_low    = !hardware_output_disable_pin_n;
   assign deselected = module_select_pin_n;

   // byte lanes 0 and 1 carry the 16-bit registers
   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (sel[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   // self-clearing bits read back zero, so merge against zero
   assign wval = merge(16'h0000, wb_dat_i, wb_sel_i);

   // configuration read refused while busy or while deselected
   assign cfg_read_fail = pend.busy || deselected;

   // read mux, reserved bits zero
   always_comb begin
      next_dat = 32'h0000_0000;
      if (sel_reset_and_output_enable) begin
         next_dat[`SOFTWARE_OUTPUT_ENABLE_BIT] = software_output_enable;
      end else if (sel_config && !cfg_read_fail) begin
         next_dat[15:0] = behaviour_configuration & `CONFIG_WMASK;
      end else if (sel_opstat) begin
         next_dat[1:0]                = resp_status;
         next_dat[`OS_ERR_LO +: 4]    = resp_err;
         next_dat[`OS_PEND_BIT]       = pend.busy;
         next_dat[`OS_DIS_BIT]        = disable_latched;
         next_dat[`OS_OFF_BIT]        = output_disable;
         next_dat[`OS_ALM_BIT]        = alarm_signal;
         next_dat[`OS_SRQ_BIT]        = srq;
         next_dat[`OS_DATA_LO +: 16]  = resp_data;
      end
   end

   // single-wait-state ack, dropped the cycle after it is given
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= next_dat;
      end
   end

   // reset bits: hard wins, and fires only after the ack edge
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hard_arm         <= 1'b0;
         hard_reset_pulse <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end else begin
         hard_arm         <= 1'b0;
         soft_reset_pulse <= 1'b0;
         hard_reset_pulse <= hard_arm;
         if (wr && sel_reset_and_output_enable && !pend.busy) begin
            if (wval[`MR_BIT]) begin
               hard_arm <= 1'b1;
            end else if (wval[`SR_BIT]) begin
               soft_reset_pulse <= 1'b1;
            end
         end
      end
   end

   // interface reset: soft reset, hard reset, or module deselected
   assign comm_interface_reset = soft_reset_pulse || hard_reset_pulse
                                 || deselected;
   assign ext_addr_reset       = comm_interface_reset;
   assign tune_start           = pend.start;

   // start a tune when an enable needs one
   assign pend.start = wr && sel_reset_and_output_enable && !pend.busy && !wval[`MR_BIT]
                       && wval[`SOFTWARE_OUTPUT_ENABLE_BIT] && tune_required
                       && !pin_low;

   // software enable; pin low forces zero and wins over a write
   always_ff @(posedge core_clk) begin
      if (srst || hard_reset_pulse) begin
         software_output_enable <= 1'b0;
      end else if (pin_low) begin
         software_output_enable <= 1'b0;
      end else if (pend.done) begin
         software_output_enable <= 1'b1;
      end else if (wr && sel_reset_and_output_enable && !pend.busy && !wval[`MR_BIT]) begin
         if (!wval[`SOFTWARE_OUTPUT_ENABLE_BIT]) begin
            software_output_enable <= 1'b0;
         end else if (!tune_required) begin
            software_output_enable <= 1'b1;
         end
      end
   end

   // pin-low latch; the set beats a clearing enable write
   always_ff @(posedge core_clk) begin
      if (srst) begin
         disable_latched <= 1'b0;
      end else if (pin_low) begin
         disable_latched <= 1'b1;
      end else if (wr && sel_reset_and_output_enable && !pend.busy && wval[`SOFTWARE_OUTPUT_ENABLE_BIT]) begin
         disable_latched <= 1'b0;
      end
   end

   // configuration: default on reset, optional nonvolatile image
   always_ff @(posedge core_clk) begin
      if (srst || hard_reset_pulse) begin
         behaviour_configuration <= `CONFIG_RESET;
      end else if (nvm_load) begin
         behaviour_configuration <= nvm_config & `CONFIG_WMASK;
      end else if (wr && sel_config) begin
         behaviour_configuration <= merge(behaviour_configuration,
                                          wb_dat_i, wb_sel_i)
                                    & `CONFIG_WMASK;
      end
   end

   // the latch replaces the pin-disable bit of the fatal status view
   always_comb begin
      fatal_view                 = fatal_status_register;
      fatal_view[`DIS_LATCH_BIT] = disable_latched;
   end

   // only the fatal bits count toward shutdown
   assign fatal_hit = |(fatal_view[`FATAL_HI:`FATAL_LO]
                        & fatal_trigger_mask[`FATAL_HI:`FATAL_LO])
                      && behaviour_configuration[`SDF_BIT];

   // output combiner and alarm, registered for clean pins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         output_disable        <= 1'b1;
         optical_output_enable <= 1'b0;
         alarm_signal          <= 1'b0;
      end else begin
         output_disable        <= fatal_hit || !software_output_enable
                                  || pin_low;
         optical_output_enable <= !fatal_hit && software_output_enable
                                  && !pin_low;
         // alarm clears once the tune completes and output is live
         alarm_signal          <= behaviour_configuration[`ADT_BIT]
                                  && (pend.busy || fatal_hit
                                      || !software_output_enable
                                      || pin_low);
      end
   end

   // response record for the last reset/enable write or configuration access; cleared by interface reset
   always_ff @(posedge core_clk) begin
      if (srst || comm_interface_reset) begin
         resp_status <= `ST_OK;
         resp_err    <= `ERR_NONE;
         resp_data   <= 16'h0000;
      end else if (pend.fail) begin
         resp_err <= `ERR_EXF;
      end else if (wr && sel_reset_and_output_enable) begin
         if (pend.busy) begin
            resp_status <= `ST_XE;
            resp_err    <= `ERR_CIP;
            resp_data   <= 16'h0000;
         end else if (pend.start) begin
            resp_status <= `ST_CP;
            resp_err    <= `ERR_NONE;
            resp_data   <= `PEND_ID;
         end else begin
            resp_status <= `ST_OK;
            resp_err    <= `ERR_NONE;
            resp_data   <= wval;
         end
      end else if (wr && sel_config) begin
         resp_status <= `ST_OK;
         resp_err    <= `ERR_NONE;
         resp_data   <= wval & `CONFIG_WMASK;
      end else if (rd && sel_config) begin
         if (cfg_read_fail) begin
            resp_status <= `ST_XE;
            resp_err    <= pend.busy ? `ERR_CIP : `ERR_CII;
            resp_data   <= 16'h0000;
         end else begin
            resp_status <= `ST_OK;
            resp_err    <= `ERR_NONE;
            resp_data   <= behaviour_configuration & `CONFIG_WMASK;
         end
      end
   end

   // service request: a failure sets it, any status write clears it;
   // the set wins when both land in one cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         srq <= 1'b0;
      end else if (pend.fail) begin
         srq <= 1'b1;
      end else if (wr && sel_opstat) begin
         srq <= 1'b0;
      end
   end

   assign service_request_n = !srq;
endmodule

// ### design/pending_op_if.sv
// carrier between the register bank and its pending-operation tracker
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface pending_op_if;
   logic start;   // one-cycle request to begin a tune
   logic busy;    // operation outstanding
   logic done;    // one-cycle success
   logic fail;    // one-cycle failure or timeout
   modport owner   (output start, input busy, input done, input fail);
   modport tracker (input start, output busy, output done, output fail);
endinterface

// ### design/pending_tracker.sv
// tracks one pending enable operation and bounds its duration
// assumes tune_done/tune_fail are synchronous one-cycle or level inputs
`timescale 1ns/100ps
`include "output_control_params.svh"
module pending_tracker #(
   parameter int unsigned LIMIT = `PEND_LIMIT_CYCLES
) (
   input  wire logic     core_clk,
   input  wire logic     srst,
   input  wire logic     abort,
   input  wire logic     tune_done,
   input  wire logic     tune_fail,
   pending_op_if.tracker op
);
   output_control_pkg::pend_state_t state;
   logic [31:0]                     count;
   logic                            expired;

   // longest allowed wait rounds down, never below one cycle
   assign expired = (count >= LIMIT - 1);
   assign op.busy = (state == output_control_pkg::pend_wait);

   // state and outcome pulses
   always_ff @(posedge core_clk) begin
      op.done <= 1'b0;
      op.fail <= 1'b0;
      if (srst || abort) begin
         state <= output_control_pkg::pend_idle;
      end else begin
         case (state)
            output_control_pkg::pend_idle: begin
               if (op.start) begin
                  state <= output_control_pkg::pend_wait;
               end
            end
            output_control_pkg::pend_wait: begin
               if (tune_fail || (expired && !tune_done)) begin
                  op.fail <= 1'b1;
                  state   <= output_control_pkg::pend_idle;
               end else if (tune_done) begin
                  op.done <= 1'b1;
                  state   <= output_control_pkg::pend_idle;
               end
            end
            default: state <= output_control_pkg::pend_idle;
         endcase
      end
   end

   // timeout counter, restarts with each operation
   always_ff @(posedge core_clk) begin
      if (srst || !op.busy) begin
         count <= 32'h0000_0000;
      end else begin
         count <= count + 32'h0000_0001;
      end
   end
endmodule

// ### testbench/output_reset_enable_control_checker.sv
// checker: bus answer timing, output gating, reset pulses
// assumes binding into the block top, one clock, srst sync high
`timescale 1ns/100ps
module output_reset_enable_control_checker #(
   parameter int unsigned PEND_LIMIT = 20
) (
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_we_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        hardware_output_disable_pin_n,
   input wire logic        module_select_pin_n,
   input wire logic        tune_start,
   input wire logic        optical_output_enable,
   input wire logic        output_disable,
   input wire logic        disable_latched,
   input wire logic        hard_reset_pulse,
   input wire logic        comm_interface_reset
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic reset_and_output_enable_wr;
   // completed reset/enable write; its effects land on this edge
   assign reset_and_output_enable_wr = wb_ack_o && wb_we_i && wb_adr_i == 8'hC8;
   a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered after one wait");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_light_gated: assert property (
      optical_output_enable |-> !output_disable && $past(hardware_output_disable_pin_n))
      else $error("light without pin high");
   a_pin_disables: assert property (
      !hardware_output_disable_pin_n |=> output_disable && disable_latched)
      else $error("pin low did not disable and latch");
   a_latch_holds: assert property (
      disable_latched && !reset_and_output_enable_wr && !hard_reset_pulse |=> disable_latched)
      else $error("latch dropped without enable write");
   a_hard_after_ack: assert property (
      hard_reset_pulse |-> $past(reset_and_output_enable_wr, 2) && $past(wb_dat_i[0], 2))
      else $error("hard reset not two cycles after its acked write");
   a_hard_self_clear: assert property (hard_reset_pulse |=> !hard_reset_pulse)
      else $error("hard reset pulse not self clearing");
   a_iface_reset: assert property (
      module_select_pin_n || hard_reset_pulse |-> comm_interface_reset)
      else $error("interface not reset on deselect or hard reset");
   a_tune_cause: assert property (tune_start |-> reset_and_output_enable_wr && wb_dat_i[3])
      else $error("tune started without enable write");
   c_hard: cover property (hard_reset_pulse);
   c_tune: cover property (tune_start);
   c_latch: cover property (!hardware_output_disable_pin_n ##1 disable_latched);
endmodule

bind output_reset_enable_control output_reset_enable_control_checker #(
   .PEND_LIMIT(PEND_LIMIT)
) chk (
   .core_clk(core_clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .hardware_output_disable_pin_n(hardware_output_disable_pin_n),
   .module_select_pin_n(module_select_pin_n), .tune_start(tune_start),
   .optical_output_enable(optical_output_enable), .output_disable(output_disable),
   .disable_latched(disable_latched), .hard_reset_pulse(hard_reset_pulse),
   .comm_interface_reset(comm_interface_reset)
);

// ### testbench/output_reset_enable_control_tb.sv
// bench for the reset/enable block: wishbone host, pins, tune engine
// assumes the checker and tune engine model are compiled beside it
`timescale 1ns/100ps
module output_reset_enable_control_tb;
   typedef struct {logic [31:0] exp; logic [31:0] msk;} note_t;
   logic        core_clk = 1'h0, srst = 1'h1, we = 1'h0, cyc = 1'h0, ack;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, r;
   logic        pin_n = 1'h1, sel_n = 1'h0, tune_req = 1'h0, nvm_load = 1'h0, fail_mode = 1'h0;
   logic [15:0] fatal = 16'h0, fmask = 16'h0700, nvm_cfg = 16'h0;
   logic        done, fail, start, light, dis, alarm, latched, hard, comm, srq_n, ext;
   logic [3:0]  delay = 4'hC;
   logic        saw_hard = 1'h0, saw_comm = 1'h0, saw_ext = 1'h0;
   int          mismatches = 0, samples_checked = 0;
   note_t       notes[$], nt;
   output_reset_enable_control #(.PEND_LIMIT(20)) uut (
      .core_clk(core_clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h3),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
      .hardware_output_disable_pin_n(pin_n), .module_select_pin_n(sel_n),
      .fatal_status_register(fatal), .fatal_trigger_mask(fmask), .tune_required(tune_req),
      .tune_done(done), .tune_fail(fail), .nvm_load(nvm_load), .nvm_config(nvm_cfg),
      .tune_start(start), .optical_output_enable(light), .output_disable(dis),
      .alarm_signal(alarm), .disable_latched(latched), .hard_reset_pulse(hard),
      .comm_interface_reset(comm), .ext_addr_reset(ext), .service_request_n(srq_n));
   tune_engine tuner (.core_clk(core_clk), .srst(srst), .tune_start(start),
      .fail_mode(fail_mode), .delay(delay), .tune_done(done), .tune_fail(fail));
   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one classic cycle; entered just after an edge, leaves one idle cycle
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'h1;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'h1 && n < 50);
      cyc <= 1'h0;
      @(posedge core_clk);
      if (n >= 50) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{e, m});
      bus(a, 1'h0, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(a, 1'h1, {16'h0, d});
   endtask
   task automatic settle;
      repeat (3) @(posedge core_clk);
   endtask
   // bounded wait: 0 for light on, 1 for service request
   task automatic await_sig(input int which);
      int n;
      n = 0;
      while (n < 100 && !(which == 0 ? light === 1'h1 : srq_n === 1'h0)) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 100) begin
         mismatches++;
         complete_run();
      end
   endtask
   // pairs each read answer with the oldest note; pulses kept sticky
   always @(posedge core_clk) begin
      if (ack === 1'h1 && we === 1'h0 && notes.size() > 0) begin
         nt = notes.pop_front();
         check("read data", nt.exp & nt.msk, rdat & nt.msk);
      end
      if (hard === 1'h1) saw_hard <= 1'h1;
      if (comm === 1'h1) saw_comm <= 1'h1;
      if (ext === 1'h1) saw_ext <= 1'h1;
   end
   initial begin
      r = $urandom(32'h6644f4c4);
      repeat (20) @(posedge core_clk);
      srst <= 1'h0;
      @(posedge core_clk);
      rd(8'hC8, 32'h0, 32'hFFFF);
      rd(8'hCC, 32'h2, 32'hFFFF);
      rd(8'h10, 32'h0, 32'hFFFFFFFF);
      check("alarm", 1'h1, alarm);
      check("disable", 1'h1, dis);
      repeat (4) begin
         r = $urandom;
         wr(8'hCC, r[15:0]);
         rd(8'hCC, {16'h0, r[15:0] & 16'h0006}, 32'hFFFF);
      end
      nvm_cfg <= 16'hFFFF;
      nvm_load <= 1'h1;
      @(posedge core_clk);
      nvm_load <= 1'h0;
      rd(8'hCC, 32'h6, 32'hFFFF);
      wr(8'hCC, 16'h0002);
      $display("done reset and configuration");
      wr(8'hC8, 16'h0008);
      rd(8'hF8, 32'h00080000, 32'hFFFF0003);
      check("light on", 1'h1, light);
      check("alarm off", 1'h0, alarm);
      wr(8'hC8, 16'h0000);
      settle();
      check("light off", 1'h0, light);
      wr(8'hC8, 16'h0008);
      for (int i = 8; i < 11; i++) begin
         fatal <= 16'h0001 << i;
         settle();
         check("fatal ungated", 1'h0, dis);
         wr(8'hCC, 16'h0006);
         settle();
         check("fatal shutdown", 1'h1, dis);
         fmask <= 16'h0000;
         settle();
         check("fatal masked", 1'h0, dis);
         fmask <= 16'h0700;
         fatal <= 16'h0000;
         wr(8'hCC, 16'h0002);
      end
      $display("done enable and fatal gating");
      pin_n <= 1'h0;
      @(posedge core_clk);
      pin_n <= 1'h1;
      settle();
      check("latched", 1'h1, latched);
      check("light after pin", 1'h0, light);
      rd(8'hC8, 32'h0, 32'hFFFF);
      wr(8'hC8, 16'h0008);
      settle();
      check("latch cleared", 1'h0, latched);
      saw_comm <= 1'h0;
      saw_ext <= 1'h0;
      wr(8'hC8, 16'h000A);
      settle();
      check("soft reset", 1'h1, saw_comm);
      check("ext addr reset", 1'h1, saw_ext);
      check("traffic kept", 1'h1, light);
      check("no hard reset", 1'h0, saw_hard);
      rd(8'hC8, 32'h8, 32'hFFFF);
      sel_n <= 1'h1;
      @(posedge core_clk);
      check("deselect reset", 1'h1, comm);
      rd(8'hCC, 32'h0, 32'hFFFF);
      sel_n <= 1'h0;
      $display("done pin, soft reset and select");
      wr(8'hC8, 16'h0000);
      tune_req <= 1'h1;
      wr(8'hC8, 16'h0008);
      rd(8'hF8, 32'h00010103, 32'hFFFF0103);
      rd(8'hCC, 32'h0, 32'hFFFF);
      check("alarm in tune", 1'h1, alarm);
      await_sig(0);
      settle();
      check("alarm after tune", 1'h0, alarm);
      wr(8'hC8, 16'h0000);
      fail_mode <= 1'h1;
      delay <= 4'h1;
      wr(8'hC8, 16'h0008);
      await_sig(1);
      check("light on failure", 1'h0, light);
      rd(8'hF8, 32'h80, 32'h1F0);
      wr(8'hF8, 16'h0000);
      settle();
      check("request cleared", 1'h1, srq_n);
      tune_req <= 1'h0;
      $display("done pending operations");
      wr(8'hC8, 16'h0008);
      wr(8'hCC, 16'h0004);
      check("light before hard", 1'h1, light);
      wr(8'hC8, 16'h000B);
      repeat (2) rd(8'hF8, 32'h0, 32'h0);
      check("hard reset", 1'h1, saw_hard);
      check("light after hard", 1'h0, light);
      rd(8'hCC, 32'h2, 32'hFFFF);
      rd(8'hC8, 32'h0, 32'hFFFF);
      $display("done hard reset");
      complete_run();
   end
endmodule

// ### testbench/tune_engine.sv
// tuning engine model: answers each tune request after a delay
// assumes tune_start is a one-cycle request on core_clk
`timescale 1ns/100ps
module tune_engine (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       tune_start,
   input  wire logic       fail_mode,
   input  wire logic [3:0] delay,
   output logic            tune_done,
   output logic            tune_fail
);
   logic [3:0] count;
   logic       running;
   // one-cycle answer; delay gives prompt or slow replies
   always_ff @(posedge core_clk) begin
      tune_done <= 1'h0;
      tune_fail <= 1'h0;
      if (srst) begin
         running <= 1'h0;
         count <= 4'h0;
      end else if (tune_start) begin
         running <= 1'h1;
         count <= delay;
      end else if (running && count != 4'h0) begin
         count <= count - 4'h1;
      end else if (running) begin
         running <= 1'h0;
         tune_done <= !fail_mode;
         tune_fail <= fail_mode;
      end
   end
endmodule
